// File: verilog/lsw_status_upper.sv
/*
  lsw_status_upper: assembles bits 31..14 of the link status word from
  autonegotiation and mac/phy state, with a small register port.
  assumes: link_state is synchronous to mclk; register port strobes are
  one cycle, never both at once; read data returned the cycle after.
*/
`timescale 1ns/100ps
`default_nettype none

// Operation
// - bit 14 reports partner ten full
// - bit 15 reports partner ten half
// - partner bits valid only after autoneg
// - bit 16 reports pause transmit enable
// - bit 17 reports pause receive enable
// - bits 19..18 encode partner pause ability
// - bit 20 reports direct attach serializer
// - bit 21 reports oem settings valid
// - bits 23..22 encode nrz or pam4
// - extended speed zero when not resolved
module lsw_status_upper
  import lsw_pkg::*;
(
  // clock and reset
  input  wire logic      mclk,
  input  wire logic      rst_n,
  // link state from autonegotiation and mac
  input  wire lsw_link_state_t link_state,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // assembled word for the response builder
  output logic [31:0]      status_word
);

  logic [2:0]  ctrl;
  logic        partner_valid;
  logic [31:0] next_word;
  logic [1:0]  pause_code;
  logic [1:0]  mod_code;
  logic [7:0]  ext_code;

  // map the resolved speed onto its extended code
  function automatic logic [7:0] lsw_ext_of(input lsw_speed_t spd);
    logic [7:0] code;
    code = LSW_EXT_NONE;
    unique case (spd)
      LSW_SPD_NONE:    code = LSW_EXT_NONE;
      LSW_SPD_10_HALF: code = LSW_EXT_10_HALF;
      LSW_SPD_10_FULL: code = LSW_EXT_10_FULL;
      LSW_SPD_TX_HALF: code = LSW_EXT_TX_HALF;
      LSW_SPD_T4:      code = LSW_EXT_T4;
      LSW_SPD_TX_FULL: code = LSW_EXT_TX_FULL;
      default:         code = LSW_EXT_NONE; // illegal speed codes
    endcase
    return code;
  endfunction

  // partner advertisement qualifier
  // serializer off, autoneg on and done
  assign partner_valid = !link_state.serdes_direct && link_state.an_enabled &&
                         link_state.an_complete;

  // partner pause field, cleared when not valid
  always_comb begin
    pause_code = LSW_PAUSE_NONE;
    // sym low bit, asym high bit
    if (partner_valid) begin
      unique case ({link_state.partner_asym_pause, link_state.partner_sym_pause})
        2'h0: pause_code = LSW_PAUSE_NONE;
        2'h1: pause_code = LSW_PAUSE_SYM;
        2'h2: pause_code = LSW_PAUSE_ASYM;
        2'h3: pause_code = LSW_PAUSE_BOTH;
      endcase
    end
  end

  // modulation field, only nrz or pam4 pass
  always_comb begin
    mod_code = 2'h0;
    if (ctrl[LSW_CTRL_MOD_EN] &&
        (link_state.modulation == LSW_MOD_NRZ || link_state.modulation == LSW_MOD_PAM4)) begin
      mod_code = link_state.modulation;
    end
  end

  // extended speed/duplex field
  always_comb begin
    ext_code = LSW_EXT_NONE;
    // zero unless autoneg done, no serializer
    if (ctrl[LSW_CTRL_EXT_EN] && link_state.an_complete && !link_state.serdes_direct) begin
      ext_code = lsw_ext_of(link_state.resolved_speed);
    end
  end

  // assemble the upper word, low bits stay zero
  always_comb begin
    next_word = LSW_WORD_RESET;
    next_word[LSW_BIT_TEN_FULL] = partner_valid && link_state.partner_ten_meg_full;
    next_word[LSW_BIT_TEN_HALF] = partner_valid && link_state.partner_ten_meg_half;
    next_word[LSW_BIT_TX_PAUSE] = link_state.tx_pause_en;
    next_word[LSW_BIT_RX_PAUSE] = link_state.rx_pause_en;
    next_word[LSW_POS_LP_PAUSE +: 2] = pause_code;
    next_word[LSW_BIT_SERDES] = link_state.serdes_direct;
    next_word[LSW_BIT_OEM_VALID] = ctrl[LSW_CTRL_OEM_VALID];
    next_word[LSW_POS_MOD +: 2] = mod_code;
    next_word[LSW_POS_EXT_SPEED +: 8] = ext_code;
  end

  // status word register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_word <= LSW_WORD_RESET;
    end else begin
      status_word <= next_word;
    end
  end

  // control register write
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl <= LSW_CTRL_RESET;
    end else if (reg_wr && reg_addr == LSW_REG_CTRL) begin
      ctrl <= reg_wdata[2:0];
    end
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        LSW_REG_CTRL:   reg_rdata <= {29'h0000_0000, ctrl};
        LSW_REG_STATUS: reg_rdata <= status_word;
        default:        reg_rdata <= 32'h0000_0000; // unmapped
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule
`default_nettype wire

// File: verilog/lsw_pkg.sv
/*
  lsw_pkg: constants and types for the upper link status word builder.
  assumes: one core clock, synchronous active-low reset, all inputs synchronous.
*/
`default_nettype none
package lsw_pkg;

  // bit positions inside the 32-bit link status word
  localparam int unsigned LSW_BIT_TEN_FULL   = 14;
  localparam int unsigned LSW_BIT_TEN_HALF   = 15;
  localparam int unsigned LSW_BIT_TX_PAUSE   = 16;
  localparam int unsigned LSW_BIT_RX_PAUSE   = 17;
  localparam int unsigned LSW_POS_LP_PAUSE   = 18;
  localparam int unsigned LSW_BIT_SERDES     = 20;
  localparam int unsigned LSW_BIT_OEM_VALID  = 21;
  localparam int unsigned LSW_POS_MOD        = 22;
  localparam int unsigned LSW_POS_EXT_SPEED  = 24;

  // partner pause encodings
  localparam logic [1:0] LSW_PAUSE_NONE = 2'h0;
  localparam logic [1:0] LSW_PAUSE_SYM  = 2'h1;
  localparam logic [1:0] LSW_PAUSE_ASYM = 2'h2;
  localparam logic [1:0] LSW_PAUSE_BOTH = 2'h3;

  // modulation encodings; 0 and 3 reserved
  localparam logic [1:0] LSW_MOD_NRZ  = 2'h1;
  localparam logic [1:0] LSW_MOD_PAM4 = 2'h2;

  // extended speed/duplex codes
  localparam logic [7:0] LSW_EXT_NONE    = 8'h00;
  localparam logic [7:0] LSW_EXT_10_HALF = 8'h01;
  localparam logic [7:0] LSW_EXT_10_FULL = 8'h02;
  localparam logic [7:0] LSW_EXT_TX_HALF = 8'h03;
  localparam logic [7:0] LSW_EXT_T4      = 8'h04;
  localparam logic [7:0] LSW_EXT_TX_FULL = 8'h05;

  // register map (byte addresses)
  localparam logic [7:0] LSW_REG_CTRL   = 8'h00;
  localparam logic [7:0] LSW_REG_STATUS = 8'h04;

  // control register fields and reset value
  localparam int unsigned LSW_CTRL_OEM_VALID = 0;
  localparam int unsigned LSW_CTRL_MOD_EN    = 1;
  localparam int unsigned LSW_CTRL_EXT_EN    = 2;
  localparam logic [2:0]  LSW_CTRL_RESET     = 3'h0;
  localparam logic [31:0] LSW_WORD_RESET     = 32'h0000_0000;

  // resolved highest common speed from autonegotiation
  typedef enum logic [2:0] {
    LSW_SPD_NONE    = 3'b000,
    LSW_SPD_10_HALF = 3'b001,
    LSW_SPD_10_FULL = 3'b010,
    LSW_SPD_TX_HALF = 3'b011,
    LSW_SPD_T4      = 3'b100,
    LSW_SPD_TX_FULL = 3'b101
  } lsw_speed_t;

  // autonegotiation and mac/phy state feeding the word
  typedef struct packed {
    logic       an_enabled;
    logic       an_complete;
    logic       serdes_direct;
    logic       partner_ten_meg_full;
    logic       partner_ten_meg_half;
    logic       partner_sym_pause;
    logic       partner_asym_pause;
    logic       tx_pause_en;
    logic       rx_pause_en;
    logic [1:0] modulation;
    lsw_speed_t resolved_speed;
  } lsw_link_state_t;

endpackage
`default_nettype wire

// File: test/lsw_mgmt_model.sv
/* lsw_mgmt_model: management side, latches each read answer.
   assumes: answer stands one cycle after the read strobe. */
`timescale 1ns/100ps
`default_nettype none
module lsw_mgmt_model (
  // bus sampling
  input  wire logic        mclk,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_rdata,
  // captured word
  output logic [31:0]      got
);
  logic rd_q;
  // take data only in the answer cycle
  always_ff @(posedge mclk) begin
    rd_q <= reg_rd;
    if (rd_q) begin
      got <= reg_rdata;
    end
  end
endmodule
`default_nettype wire

// File: test/lsw_status_upper_assertions.sv
/* lsw_status_upper_assertions: port checks of the status builder.
   assumes: bound to lsw_status_upper, single clock domain. */
`timescale 1ns/100ps
`default_nettype none
module lsw_status_upper_assertions
  import lsw_pkg::*;
(
  // clock and reset
  input wire logic            mclk,
  input wire logic            rst_n,
  // watched inputs
  input wire lsw_link_state_t link_state,
  input wire logic            reg_rd,
  // watched outputs
  input wire logic [31:0]     reg_rdata,
  input wire logic [31:0]     status_word
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic v;
  // partner fields valid
  assign v = link_state.an_enabled & link_state.an_complete & ~link_state.serdes_direct;
  // previous edge was out of reset, so the word was updated from inputs
  sequence s_up;
    $past(rst_n);
  endsequence
  a_ten_full: assert property (s_up |->
    status_word[14] == $past(v & link_state.partner_ten_meg_full)) else $error("bit 14");
  a_ten_half: assert property (s_up |->
    status_word[15] == $past(v & link_state.partner_ten_meg_half)) else $error("bit 15");
  a_gate_off: assert property (s_up ##0 !$past(v) |->
    status_word[19:18] == 2'h0) else $error("pause not gated");
  a_pause_code: assert property (s_up ##0 $past(v) |-> status_word[19:18] ==
    $past({link_state.partner_asym_pause, link_state.partner_sym_pause})) else $error("pause");
  a_flow_flags: assert property (s_up |-> status_word[17:16] ==
    $past({link_state.rx_pause_en, link_state.tx_pause_en})) else $error("flow flags");
  a_serdes_bit: assert property (s_up |->
    status_word[20] == $past(link_state.serdes_direct)) else $error("serdes bit");
  a_ext_zero: assert property (s_up ##0
    $past(!link_state.an_complete | link_state.serdes_direct) |-> status_word[31:24] == 8'h0)
    else $error("ext not zero");
  a_ext_range: assert property (status_word[31:24] <= 8'h05) else $error("ext code");
  a_mod_legal: assert property (status_word[23:22] != 2'h3) else $error("mod code");
  a_low_zero: assert property (status_word[13:0] == 14'h0) else $error("low bits");
  a_rdata_idle: assert property (!$past(reg_rd) |->
    reg_rdata == 32'h0) else $error("rdata idle");
endmodule
`default_nettype wire

// File: test/test_lsw_status_upper.sv
/* test_lsw_status_upper: bench for the upper status word builder.
   assumes: package, design, checker and mgmt model compiled first. */
`timescale 1ns/100ps
`default_nettype none
module test_lsw_status_upper;
  import lsw_pkg::*;
  `define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
  logic            mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0]      reg_addr = 8'h00;
  logic [31:0]     reg_wdata = 32'h0, reg_rdata, status_word, got;
  lsw_link_state_t link_state = '0, t;
  logic [2:0]      c;
  int              num_errors = 0, tests_run = 0;
  // 40 MHz clock
  always #12.5 mclk = ~mclk;
  lsw_status_upper uut (.mclk, .rst_n, .link_state, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .status_word);
  lsw_mgmt_model mgmt (.mclk, .reg_rd, .reg_rdata, .got);
  // expected word from state and control
  function automatic logic [31:0] ex(lsw_link_state_t s, logic [2:0] k);
    logic v;
    v = s.an_enabled & s.an_complete & ~s.serdes_direct;
    ex = {(k[2] & s.an_complete & ~s.serdes_direct) ? {5'h0, s.resolved_speed} : 8'h0,
      (k[1] && ^s.modulation) ? s.modulation : 2'h0, k[0], s.serdes_direct,
      v ? {s.partner_asym_pause, s.partner_sym_pause} : 2'h0, s.rx_pause_en,
      s.tx_pause_en, v & s.partner_ten_meg_half, v & s.partner_ten_meg_full, 14'h0};
  endfunction
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task rd(input string n, input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    #1 `CHK(n, e, got)
    @(posedge mclk);
  endtask
  task end_sim;
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // reset, then sweep link states and control values
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rd("ctrl", LSW_REG_CTRL, 32'h0);
    rd("spare", 8'h08, 32'h0);
    for (int i = 0; i < 64; i++) begin
      t = lsw_link_state_t'({i[5:3], 11'(i * 695)});
      t.resolved_speed = lsw_speed_t'(i % 6);
      c = 3'(i + i / 8);
      link_state <= t;
      wr(LSW_REG_CTRL, {29'h1fff_ffff, c});
      wr(LSW_REG_STATUS, 32'hffff_ffff);
      rd("ctrl", LSW_REG_CTRL, {29'h0, c});
      rd("status", LSW_REG_STATUS, ex(t, c));
      `CHK("word", ex(t, c), status_word)
    end
    end_sim;
  end
endmodule
bind lsw_status_upper lsw_status_upper_assertions chk (.mclk, .rst_n, .link_state,
  .reg_rd, .reg_rdata, .status_word);
`default_nettype wire
